// [bench/ctmc_bus_model.sv]
// Wired bus model: the bus is dominant while any node drives it.
`timescale 1ns/10ps
`default_nettype none
module ctmc_bus_model (
    // Node drives
    input wire logic drive_a,
    input wire logic other_dominant,
    // Bus level
    output logic bus_dominant
);
    assign bus_dominant = drive_a | other_dominant;
endmodule
`default_nettype wire

// [bench/ctmc_top_assertions.sv]
// Checker for the mode-control block.
`timescale 1ns/10ps
`default_nettype none
module ctmc_chk #(
    parameter MODE_CYCLES = 8,
    parameter TXTO_CYCLES = 16
) (
    // Block ports
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic receive_only_select,
    input wire logic tx_data,
    input wire logic rx_data,
    input wire logic bus_dominant,
    input wire logic bus_drive_dominant,
    input wire logic normal_mode,
    input wire logic tx_timeout
);
    localparam int MODE_MAX = MODE_CYCLES + 8;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    rx_rec_a: assert property (!bus_dominant [*4] |-> rx_data) else $error("rx low");
    rx_dom_a: assert property (bus_dominant [*4] |-> !rx_data) else $error("rx high");
    gate_off_a: assert property (!normal_mode |-> !bus_drive_dominant) else $error("drv");
    ro_exit_a: assert property (receive_only_select [*5] |-> !normal_mode) else $error("ro");
    mode_entry_a: assert property ($fell(receive_only_select) |->
        ##[1:MODE_MAX] (normal_mode || receive_only_select)) else $error("slow mode");
    tx_drive_a: assert property ((normal_mode && !tx_timeout && !tx_data) [*4]
        |-> bus_drive_dominant) else $error("no dom");
    tx_quiet_a: assert property (tx_data [*4] |-> !bus_drive_dominant) else $error("dom");
    to_cut_a: assert property (tx_timeout |=> !bus_drive_dominant) else $error("to drv");
endmodule
bind ctmc_top ctmc_chk #(.MODE_CYCLES(MODE_CYCLES), .TXTO_CYCLES(TXTO_CYCLES)) i_chk (.*);
`default_nettype wire

// [bench/tb_top.sv]
// Testbench for the mode-control block.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic sys_clk = 0, rst_n = 0, sel = 1, tx = 1, oth = 0;
    logic rx, bus, drv, nrm, tmo;
    int bad_count = 0, n_checks = 0, cyc = 0;
    always #2.5 sys_clk = ~sys_clk;
    ctmc_bus_model i_ctmc_bus_model (.drive_a(drv), .other_dominant(oth), .bus_dominant(bus));
    ctmc_top #(.MODE_CYCLES(8), .TXTO_CYCLES(16)) i_ctmc_top (.sys_clk(sys_clk), .rst_n(rst_n),
        .receive_only_select(sel), .tx_data(tx), .rx_data(rx), .bus_dominant(bus),
        .bus_drive_dominant(drv), .normal_mode(nrm), .tx_timeout(tmo));
    task automatic chk(input string n, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic enter_normal;
        sel = 0;
        for (int i = 0; i < 16 && nrm !== 1'b1; i++) begin
            step(1);
            if (nrm !== 1'b1) chk("drv_gated", 0, drv);
        end
        chk("normal", 1, nrm);
    endtask
    task automatic t_tx_low;
        tx = 0;
        step(40);
        chk("ro_drv", 0, drv);
        chk("ro_tmo", 0, tmo);
        chk("ro_rx", 1, rx);
        enter_normal();
        step(4);
        chk("tx_dom", 1, drv);
        chk("rx_dom", 0, rx);
        step(20);
        chk("timeout", 1, tmo);
        sel = 1;
        step(4);
        chk("exit", 0, nrm);
        chk("exit_drv", 0, drv);
        step(4);
        chk("exit_rx", 1, rx);
    endtask
    task automatic t_bus_dom;
        tx = 1;
        oth = 1;
        step(4);
        chk("ro_rx_dom", 0, rx);
        enter_normal();
        chk("quiet_drv", 0, drv);
        chk("other_rx", 0, rx);
        tx = 0;
        step(20);
        chk("fall_to", 1, tmo);
        tx = 1;
        step(4);
        chk("to_clear", 0, tmo);
        oth = 0;
        tx = 0;
        step(4);
        chk("live_drv", 1, drv);
        sel = 1;
        step(4);
        chk("off_drv", 0, drv);
    endtask
    initial begin
        step(6);
        rst_n = 1;
        t_tx_low();
        t_bus_dom();
        final_report();
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            final_report();
        end
    end
endmodule
`default_nettype wire

// [logic/ctmc_regs.vh]
// Constants for the CAN transceiver mode-control block.
`ifndef CTMC_REGS_VH
`define CTMC_REGS_VH
`define CTMC_CLK_MHZ 200
`define CTMC_MODE_TIME_US 20
`define CTMC_MODE_CYCLES (`CTMC_MODE_TIME_US * `CTMC_CLK_MHZ)
`define CTMC_TXTO_CYCLES 200000
`define CTMC_ST_RXONLY 2'h0
`define CTMC_ST_TO_NORM 2'h1
`define CTMC_ST_NORMAL 2'h2
`endif

// [logic/ctmc_sync.v]
// Two-flop synchroniser for one level.
`timescale 1ns/10ps
`default_nettype none
module ctmc_sync #(
    parameter RESET_VAL = 1'b0
) (
    // Clock and reset
    input wire sys_clk,
    input wire rst_n,
    // Level
    input wire d_in,
    output reg q_out
);
    reg meta_r;
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= RESET_VAL;
            q_out <= RESET_VAL;
        end else begin
            meta_r <= d_in;
            q_out <= meta_r;
        end
    end
endmodule
`default_nettype wire

// [logic/ctmc_timer.v]
// Down-counter that runs while its start level is held.
`timescale 1ns/10ps
`default_nettype none
module ctmc_timer #(
    parameter W = 24,
    parameter [W-1:0] COUNT = 24'h000001
) (
    // Clock and reset
    input wire sys_clk,
    input wire rst_n,
    // Control
    input wire run,
    output wire expired
);
    reg [W-1:0] cnt_r;
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= {W{1'b0}};
        end else if (!run) begin
            cnt_r <= COUNT;
        end else if (cnt_r != {W{1'b0}}) begin
            cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
        end
    end
    assign expired = run && (cnt_r == {W{1'b0}});
endmodule
`default_nettype wire

// [logic/ctmc_top.v]
// Mode control of a high-speed CAN transceiver: mode select, transmit gating, receive path.
// Notes on behaviour
// (RULE1) Mode select low leads to normal operation with transmitter allowed.
// (RULE2) Mode select high leads to receive-only operation, unconditionally.
// (RULE3) Mode change ignores the bus level, including stuck buses.
// (RULE4) Mode change ignores the transmit input level.
// (RULE5) Only the mode-select input triggers mode changes, and only when powered.
// (RULE6) Transmit low on entering normal mode drives dominant once normal.
// (RULE7) Transmit time-out supervision is active only in normal operation.
// (RULE8) Time-out timer starts on normal entry with transmit low or on its fall.
// (RULE9) Returning mode select high disables the transmitter at once.
// (RULE10) Transmitter stays off until the change to normal mode completes.
// (RULE11) Receiver is active and follows the bus in both modes.
// (RULE12) Receive output follows the bus through every transition, no blanking.
// (RULE13) Receive output high for recessive bus, low for dominant.
// (RULE14) Transmit high drives nothing; receive reports whatever other nodes drive.
// (RULE15) A mode change completes within 20 microseconds.
// (RULE16) Mode select is synchronised and the transition timed by a counter.
`timescale 1ns/10ps
`default_nettype none
`include "ctmc_regs.vh"
module ctmc_top #(
    parameter MODE_CYCLES = `CTMC_MODE_CYCLES,
    parameter TXTO_CYCLES = `CTMC_TXTO_CYCLES
) (
    // Clock and reset
    input wire sys_clk,
    input wire rst_n,
    // Controller side
    input wire receive_only_select,
    input wire tx_data,
    output reg rx_data,
    // Bus side
    input wire bus_dominant,
    output reg bus_drive_dominant,
    // Status
    output wire normal_mode,
    output wire tx_timeout
);
    wire mode_sel_s;
    wire tx_s;
    wire bus_s;
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg tx_prev_r;
    reg txto_arm_r;
    reg txto_arm_nxt;
    wire trans_done;
    wire txto_exp;
    // Synchroniser and state steps add about four cycles, so the counter loads less.
    localparam integer MODE_LOAD_I = MODE_CYCLES - 4;

    // Pins pass two flip-flops before use.
    ctmc_sync #(.RESET_VAL(1'b1)) u_sync_mode (.sys_clk(sys_clk), .rst_n(rst_n),
        .d_in(receive_only_select), .q_out(mode_sel_s)); // RULE16
    ctmc_sync #(.RESET_VAL(1'b1)) u_sync_tx (.sys_clk(sys_clk), .rst_n(rst_n),
        .d_in(tx_data), .q_out(tx_s));
    ctmc_sync #(.RESET_VAL(1'b0)) u_sync_bus (.sys_clk(sys_clk), .rst_n(rst_n),
        .d_in(bus_dominant), .q_out(bus_s));

    // Transition interval counter.
    ctmc_timer #(.W(24), .COUNT(MODE_LOAD_I[23:0])) u_mode_tmr (.sys_clk(sys_clk),
        .rst_n(rst_n), .run(state_r == `CTMC_ST_TO_NORM), .expired(trans_done)); // RULE15

    // Transmit time-out counter, runs only while armed in normal mode.
    ctmc_timer #(.W(24), .COUNT(TXTO_CYCLES[23:0])) u_txto_tmr (.sys_clk(sys_clk),
        .rst_n(rst_n), .run(txto_arm_r), .expired(txto_exp)); // RULE7

    // Mode state machine: only the mode select and the transition counter steer it, never bus or transmit.
    always @* begin
        state_nxt = state_r;
        case (state_r)
            `CTMC_ST_RXONLY: begin
                if (!mode_sel_s) begin
                    state_nxt = `CTMC_ST_TO_NORM; // RULE1 RULE3 RULE4 RULE5
                end
            end
            `CTMC_ST_TO_NORM: begin
                if (mode_sel_s) begin
                    state_nxt = `CTMC_ST_RXONLY; // RULE2
                end else if (trans_done) begin
                    state_nxt = `CTMC_ST_NORMAL; // RULE10 RULE16
                end
            end
            `CTMC_ST_NORMAL: begin
                if (mode_sel_s) begin
                    state_nxt = `CTMC_ST_RXONLY; // RULE2 RULE9
                end
            end
            default: begin
                state_nxt = `CTMC_ST_RXONLY;
            end
        endcase
    end

    // Time-out arming: on normal entry with transmit low, or a fall in normal mode.
    always @* begin
        txto_arm_nxt = txto_arm_r;
        if (state_nxt != `CTMC_ST_NORMAL || tx_s) begin
            txto_arm_nxt = 1'b0; // RULE7
        end else if (state_r != `CTMC_ST_NORMAL && !tx_s) begin
            txto_arm_nxt = 1'b1; // RULE8
        end else if (tx_prev_r && !tx_s) begin
            txto_arm_nxt = 1'b1; // RULE8
        end
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= `CTMC_ST_RXONLY;
            tx_prev_r <= 1'b1;
            txto_arm_r <= 1'b0;
            rx_data <= 1'b1;
            bus_drive_dominant <= 1'b0;
        end else begin
            state_r <= state_nxt;
            tx_prev_r <= tx_s;
            txto_arm_r <= txto_arm_nxt;
            rx_data <= !bus_s; // RULE11 RULE12 RULE13 RULE14
            bus_drive_dominant <= (state_nxt == `CTMC_ST_NORMAL) && !tx_s &&
                !(txto_arm_r && txto_exp); // RULE6 RULE9 RULE10 RULE14
        end
    end

    assign normal_mode = (state_r == `CTMC_ST_NORMAL);
    assign tx_timeout = txto_arm_r && txto_exp;
endmodule
`default_nettype wire
